// File: bench/assf_modem_model.sv
// remote modem model driving carrier detect and clear-to-send pins
`default_nettype none
module assf_modem_model (
  input  wire logic       mclk,
  input  wire logic [2:0] want,                   // carrier, cts0, shared pin
  output logic            carrierDetectIn = 1'b0,
  output logic            cts0In          = 1'b0,
  output logic            sharedPin1      = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  // pins follow the requested levels just after an edge
  always @(posedge mclk) begin
    carrierDetectIn <= want[2];
    cts0In          <= want[1];
    sharedPin1      <= want[0];
  end
endmodule
`default_nettype wire

// File: bench/assf_top_props.sv
// checker: bus answers and carrier hold relations at the top ports
`default_nettype none
module assf_top_props
  import assf_pkg::*;
(
  input wire logic        mclk,
  input wire logic        nrst,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        carrierDetectIn,
  input wire logic [1:0]  rxResetOut
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  // channel 1 has no carrier, so its receiver is never held
  AST_RX1_FREE: assert property (!rxResetOut[1]) else $error("channel 1 receiver held");
  // steady carrier holds the channel 0 receiver
  AST_CD_HOLDS: assert property (carrierDetectIn [*6] |-> rxResetOut[0])
    else $error("carrier high but receiver free");
  // no release while carrier still high
  AST_CD_STAYS: assert property (rxResetOut[0] && carrierDetectIn |=> rxResetOut[0])
    else $error("receiver released during carrier");
  // release only after the pin has fallen
  AST_CD_FALL: assert property ($fell(rxResetOut[0]) |-> !$past(carrierDetectIn, 3))
    else $error("receiver released before carrier fell");
  // write answered in bounded time
  AST_WR_RESP: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:3] s_axi_bvalid) else $error("write not answered");
  // read answered one edge after address taken
  AST_RD_RESP: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  // no new read address while data pending
  AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("ar ready early");
  // unmapped reads return zero
  AST_SLVERR_ZERO: assert property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR
    |-> s_axi_rdata == 32'h0) else $error("error read data not zero");
endmodule
bind assf_top assf_top_props i_assf_top_props (.mclk, .nrst, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .s_axi_rresp, .s_axi_rdata, .carrierDetectIn, .rxResetOut);
`default_nettype wire

// File: bench/async_serial_status_flags_test.sv
// self-checking bench for the serial status and interrupt block
`default_nettype none
module async_serial_status_flags_test;
  timeunit 1ns;
  timeprecision 1ps;
  import assf_pkg::*;
  typedef struct packed {logic wr; logic [7:0] a; logic [7:0] d; logic [7:0] e; logic [1:0] r;} assf_row_t;
  logic        mclk = 1'b0, nrst = 1'b0;
  logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0, got;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'h1;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp, wresp, rxResetOut;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  rxDone = '0, rxParityBad = '0, rxStopBad = '0, rdDataRd = '0, txWr = '0, txLoad = '0;
  logic        carrierDetectIn, cts0In, sharedPin1, clockedSerialRx, irq;
  logic [2:0]  want = 3'b000;  // modem pin requests
  int          nErrors = 0, cmpCount = 0;
  // register table: access, reset and unmapped cases
  localparam assf_row_t ROWS [9] = '{
    '{1'b0, ADDR_ASYNC_CHAN0_STATUS, 8'h00, STAT_RESET, RESP_OKAY}, '{1'b0, ADDR_ASYNC_CHAN1_STATUS, 8'h00, STAT_RESET, RESP_OKAY},
    '{1'b0, ADDR_CTRL0, 8'h00, CTRL_RESET, RESP_OKAY}, '{1'b1, ADDR_ASYNC_CHAN0_STATUS, 8'hff, 8'h0b, RESP_OKAY},
    '{1'b1, ADDR_ASYNC_CHAN1_STATUS, 8'hfb, 8'h0b, RESP_OKAY}, '{1'b1, ADDR_ASYNC_CHAN0_STATUS, 8'h00, STAT_RESET, RESP_OKAY},
    '{1'b1, ADDR_ASYNC_CHAN1_STATUS, 8'h00, STAT_RESET, RESP_OKAY}, '{1'b1, ADDR_CTRL1, 8'h0a, 8'h0a, RESP_OKAY},
    '{1'b1, 8'h40, 8'h55, 8'h00, RESP_SLVERR}};
  assf_top i_assf_top (.mclk, .nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .carrierDetectIn, .cts0In, .sharedPin1, .rxDone, .rxParityBad, .rxStopBad,
    .rdDataRd, .txWr, .txLoad, .rxResetOut, .clockedSerialRx, .irq);
  assf_modem_model i_assf_modem_model (.mclk, .want, .carrierDetectIn, .cts0In, .sharedPin1);
  // free-running clock
  initial begin
    forever #2 mclk = ~mclk;
  end
  // counts a comparison, reports a mismatch
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    cmpCount++;
    if (seen !== exp) begin
      nErrors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // bus write: address and data offered together, held until taken
  task automatic busWr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge mclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    wresp = s_axi_bresp;
  endtask
  // bus read: data and response taken at the rvalid edge
  task automatic busRd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge mclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    d = s_axi_rdata[7:0];
    resp = s_axi_rresp;
  endtask
  task automatic rdChk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    busRd(a, d);
    chk("status read", e, d);
  endtask
  // channel 0 byte completion with parity and stop qualifiers
  task automatic rxByte(input logic [1:0] q);
    @(posedge mclk);
    rxParityBad <= {1'b0, q[1]};
    rxStopBad <= {1'b0, q[0]};
    rxDone <= 2'b01;
    @(posedge mclk);
    rxDone <= 2'b00;
    repeat (4) @(posedge mclk);
  endtask
  // channel 0 strobes: holding read, holding write, shift load
  task automatic pulse(input logic [2:0] k);
    @(posedge mclk);
    {rdDataRd[0], txWr[0], txLoad[0]} <= k;
    @(posedge mclk);
    {rdDataRd[0], txWr[0], txLoad[0]} <= 3'b000;
    repeat (4) @(posedge mclk);
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmpCount, nErrors);
    if (nErrors == 0 && cmpCount > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // hang guard
  initial begin
    repeat (20000) @(posedge mclk);
    nErrors++;
    close_out();
  end
  initial begin
    repeat (16) @(posedge mclk);
    nrst <= 1'b1;
    foreach (ROWS[i]) begin
      if (ROWS[i].wr) begin
        busWr(ROWS[i].a, ROWS[i].d);
        chk("table wresp", ROWS[i].r, wresp);
      end
      busRd(ROWS[i].a, got);
      chk("table data", ROWS[i].e, got);
      chk("table resp", ROWS[i].r, resp);
    end
    $display("register table done");
    busWr(ADDR_CTRL0, 8'h0a);
    rxByte(2'b11);
    rdChk(ADDR_ASYNC_CHAN0_STATUS, 8'hb2);
    pulse(3'b100);
    rdChk(ADDR_ASYNC_CHAN0_STATUS, 8'h32);
    busWr(ADDR_CTRL0, 8'h02);
    rdChk(ADDR_ASYNC_CHAN0_STATUS, 8'h02);
    busWr(ADDR_CTRL0, 8'h08);
    rxByte(2'b10);
    rxByte(2'b00);
    rdChk(ADDR_ASYNC_CHAN0_STATUS, 8'hc2);
    pulse(3'b100);
    busWr(ADDR_CTRL0, 8'h00);
    rdChk(ADDR_ASYNC_CHAN0_STATUS, 8'h02);
    $display("error flags done");
    busWr(ADDR_IRQST, 8'h0f);
    busWr(ADDR_IRQMSK, 8'h01);
    busWr(ADDR_ASYNC_CHAN0_STATUS, 8'h08);
    rxByte(2'b00);
    rdChk(ADDR_IRQST, 8'h01);
    chk("rx irq", 1'b1, irq);
    busWr(ADDR_IRQMSK, 8'h00);
    busWr(ADDR_IRQST, 8'h01);
    rxByte(2'b00);
    chk("masked irq", 1'b0, irq);
    pulse(3'b100);
    busWr(ADDR_CTRL0, 8'h00);
    busWr(ADDR_ASYNC_CHAN0_STATUS, 8'h01);
    busWr(ADDR_IRQST, 8'h0f);
    busWr(ADDR_IRQMSK, 8'h02);
    repeat (4) @(posedge mclk);
    chk("tx irq", 1'b1, irq);
    pulse(3'b010);
    busWr(ADDR_IRQST, 8'h02);
    rdChk(ADDR_ASYNC_CHAN0_STATUS, 8'h01);
    rdChk(ADDR_IRQST, 8'h00);
    pulse(3'b001);
    rdChk(ADDR_ASYNC_CHAN0_STATUS, 8'h03);
    want <= 3'b010;
    repeat (8) @(posedge mclk);
    rdChk(ADDR_ASYNC_CHAN0_STATUS, 8'h01);
    want <= 3'b000;
    busWr(ADDR_MODE, 8'h01);
    pulse(3'b010);
    rdChk(ADDR_ASYNC_CHAN0_STATUS, 8'h03);
    busWr(ADDR_MODE, 8'h00);
    $display("interrupt and transmit done");
    busWr(ADDR_ASYNC_CHAN0_STATUS, 8'h08);
    busWr(ADDR_IRQST, 8'h0f);
    busWr(ADDR_IRQMSK, 8'h01);
    want <= 3'b100;
    repeat (8) @(posedge mclk);
    chk("rx held", 1'b1, rxResetOut[0]);
    chk("carrier irq", 1'b1, irq);
    rxByte(2'b11);
    rdChk(ADDR_ASYNC_CHAN0_STATUS, 8'h0e);
    want <= 3'b000;
    repeat (8) @(posedge mclk);
    busRd(ADDR_ASYNC_CHAN0_STATUS, got);
    chk("carrier kept until read", 8'h0e, got);
    rdChk(ADDR_ASYNC_CHAN0_STATUS, 8'h0a);
    chk("rx free", 1'b0, rxResetOut[0]);
    want <= 3'b001;
    repeat (8) @(posedge mclk);
    chk("shared pin rx", 1'b1, clockedSerialRx);
    busWr(ADDR_ASYNC_CHAN1_STATUS, 8'h04);
    repeat (4) @(posedge mclk);
    chk("shared pin rx", 1'b0, clockedSerialRx);
    rdChk(ADDR_ASYNC_CHAN1_STATUS, 8'h04);
    want <= 3'b000;
    $display("carrier and shared pin done");
    nrst <= 1'b0;
    repeat (16) @(posedge mclk);
    nrst <= 1'b1;
    rdChk(ADDR_ASYNC_CHAN1_STATUS, STAT_RESET);
    rdChk(ADDR_CTRL0, CTRL_RESET);
    chk("irq after reset", 1'b0, irq);
    $display("second reset done");
    close_out();
  end
endmodule
`default_nettype wire

// File: rtl/assf_channel.sv
// one channel's status flags and interrupt requests
`default_nettype none
module assf_channel
  import assf_pkg::*;
#(
  parameter bit HAS_CARRIER = 1'b1
) (
  input  wire logic       mclk,
  input  wire logic       nrst,
  input  wire logic       haltMode,     // io halt mode
  input  wire logic       carrierSync,  // synchronised carrier-detect pin
  input  wire logic       ctsSync,      // synchronised clear-to-send
  input  wire logic       paritySelect, // parity checking enabled
  input  wire logic       errClearWr,   // control written with clear bit 0
  input  wire logic       rxDone,       // shift register completed a byte
  input  wire logic       rxParityBad,
  input  wire logic       rxStopBad,
  input  wire logic       rdDataRd,     // holding register read
  input  wire logic       statRd,       // status register read
  input  wire logic       txWr,         // byte written to holding register
  input  wire logic       txLoad,       // byte moved to shift register
  input  wire logic       statWr,
  input  wire logic [7:0] statWdata,
  output logic      [7:0] status,
  output logic            rxReset,
  output logic            rxIrq,
  output logic            txIrq
);
  // all channel state
  typedef struct packed {
    logic full, overrun_flag, perr, ferr, receive_irq_enable, sel, cd, temp, transmit_irq_enable;
    logic cdPrev;  // previous carrier level
    logic cdFell;  // fall seen, awaiting status read
    logic rxIrq;
  } assf_chan_t;
  assf_chan_t s_q, s_d;
  logic errClr;
  logic rxGate;

  // next-state logic
  always_comb begin
    s_d    = s_q;
    errClr = errClearWr | (HAS_CARRIER & carrierSync) | haltMode; // R2
    rxGate = rxDone & ~(HAS_CARRIER & s_q.cd);                    // R8
    s_d.cdPrev = carrierSync;
    // receive holding full
    if (rdDataRd || (HAS_CARRIER && carrierSync) || haltMode) begin
      s_d.full = 1'b0;
    end
    if (rxGate) begin
      s_d.full = 1'b1; // R13
    end
    // error flags, set wins over clear
    if (errClr) begin
      s_d.overrun_flag = 1'b0;
      s_d.perr = 1'b0;
      s_d.ferr = 1'b0;
    end
    if (rxGate && s_q.full) begin
      s_d.overrun_flag = 1'b1; // R14
    end
    if (rxGate && rxParityBad && paritySelect) begin
      s_d.perr = 1'b1; // R1
    end
    if (rxGate && rxStopBad) begin
      s_d.ferr = 1'b1; // R3
    end
    // carrier status
    if (HAS_CARRIER) begin
      if (s_q.cdPrev && !carrierSync) begin
        s_d.cdFell = 1'b1;
      end
      if (statRd && s_q.cdFell && !carrierSync) begin
        s_d.cd     = 1'b0; // R7
        s_d.cdFell = 1'b0;
      end
      if (carrierSync) begin
        s_d.cd = 1'b1; // R6
      end
    end
    // transmit holding empty
    if (txWr) begin
      s_d.temp = 1'b0; // R9
    end
    if (txLoad) begin
      s_d.temp = 1'b1; // R9
    end
    if (ctsSync) begin
      s_d.temp = 1'b0; // R11
    end
    if (haltMode) begin
      s_d.temp = 1'b1; // R10
    end
    // writable bits only
    if (statWr) begin
      s_d.receive_irq_enable = statWdata[BIT_RIE]; // R16
      s_d.transmit_irq_enable = statWdata[BIT_TIE];
      if (!HAS_CARRIER) begin
        s_d.sel = statWdata[BIT_CD];
      end
    end
    // receive request pulses on flag set or carrier rise
    s_d.rxIrq = s_q.receive_irq_enable & (((s_d.full & ~s_q.full) | (s_d.overrun_flag & ~s_q.overrun_flag) | (s_d.perr & ~s_q.perr)
              | (s_d.ferr & ~s_q.ferr)) | (HAS_CARRIER & carrierSync & ~s_q.cdPrev)); // R4 R5
  end

  // state register
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      s_q      <= '0;
      s_q.temp <= 1'b1; // R10
    end else begin
      s_q <= s_d;
    end
  end

  assign status  = {s_q.full, s_q.overrun_flag, s_q.perr, s_q.ferr, s_q.receive_irq_enable,
                    HAS_CARRIER ? s_q.cd : s_q.sel, s_q.temp, s_q.transmit_irq_enable};
  assign rxReset = HAS_CARRIER & s_q.cd; // R8
  assign rxIrq   = s_q.rxIrq;
  assign txIrq   = s_q.transmit_irq_enable & s_q.temp;   // R12
endmodule
`default_nettype wire

// File: rtl/assf_pkg.sv
// package: register map, field positions and reset values for the serial status block
// Function
// R1: parity error sets flag when parity checking enabled
// R2: error clear bit, carrier, halt, reset clear errors
// R3: stop bit sampled zero sets framing error
// R4: receive enable requests irq on receive flags
// R5: channel 0 carrier rising edge requests irq
// R6: carrier status bit set while carrier high
// R7: carrier bit clears on status read after fall
// R8: carrier status holds channel 0 receiver reset
// R9: holding write clears empty, shift load sets
// R10: halt mode and reset force empty flag
// R11: clear-to-send high holds empty flag low
// R12: transmit irq when enable and empty set
// R13: loaded byte sets full, data read clears
// R14: byte completes while full sets overrun
// R15: handshake select routes shared pin function
// R16: status writes change only writable bits
`default_nettype none
package assf_pkg;
  // byte addresses of the registers
  localparam logic [7:0] ADDR_CTRL0   = 8'h00; // control: parity select, error clear
  localparam logic [7:0] ADDR_CTRL1   = 8'h04;
  localparam logic [7:0] ADDR_ASYNC_CHAN0_STATUS   = 8'h08; // channel 0 status (offset chosen)
  localparam logic [7:0] ADDR_ASYNC_CHAN1_STATUS   = 8'h14; // channel 1 status, printed 0x05 as index
  localparam logic [7:0] ASYNC_CHAN1_STATUS_INDEX  = 8'h05;
  localparam logic [7:0] ADDR_IRQST   = 8'h18; // sticky event status, write one to clear
  localparam logic [7:0] ADDR_IRQMSK  = 8'h1c; // event mask
  localparam logic [7:0] ADDR_MODE    = 8'h20; // bit0 io halt mode
  // status field positions
  localparam int BIT_FULL  = 7;
  localparam int BIT_OVERRUN_FLAG  = 6;
  localparam int BIT_PERR  = 5;
  localparam int BIT_FERR  = 4;
  localparam int BIT_RIE   = 3;
  localparam int BIT_CD    = 2; // chan0 carrier; chan1 handshake select
  localparam int BIT_TEMP  = 1;
  localparam int BIT_TIE   = 0;
  // control field positions
  localparam int BIT_PSEL  = 1; // parity select
  localparam int BIT_EFC   = 3; // error flag clear, writing 0 clears
  // irq status layout: bit0 chan0 rx, bit1 chan0 tx, bit2 chan1 rx, bit3 chan1 tx
  localparam int NIRQ      = 4;
  localparam logic [7:0] STAT_RESET = 8'h02;
  localparam logic [7:0] CTRL_RESET = 8'h08;
  localparam logic [1:0] RESP_OKAY  = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage
`default_nettype wire

// File: rtl/assf_top.sv
// top: bus slave, pin synchronisers, two channels and interrupt aggregation
//
// The AXI4-Lite register port was left to the implementer.
`default_nettype none
module assf_top
  import assf_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       nrst,
  // axi4-lite slave
  // write address channel
  input  wire logic [7:0] s_axi_awaddr,
  input  wire logic       s_axi_awvalid,
  output logic            s_axi_awready,
  // write data channel
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0] s_axi_wstrb,
  input  wire logic       s_axi_wvalid,
  output logic            s_axi_wready,
  // write response channel
  output logic      [1:0] s_axi_bresp,
  output logic            s_axi_bvalid,
  input  wire logic       s_axi_bready,
  // read address channel
  input  wire logic [7:0] s_axi_araddr,
  input  wire logic       s_axi_arvalid,
  output logic            s_axi_arready,
  // read data channel
  output logic     [31:0] s_axi_rdata,
  output logic      [1:0] s_axi_rresp,
  output logic            s_axi_rvalid,
  input  wire logic       s_axi_rready,
  // pins
  input  wire logic       carrierDetectIn,  // channel 0 carrier detect
  input  wire logic       cts0In,           // channel 0 clear-to-send
  input  wire logic       sharedPin1,       // channel 1 cts or clocked-serial rx
  // receiver / transmitter events, same clock
  input  wire logic [1:0] rxDone,
  // qualifiers valid with the completion pulse
  input  wire logic [1:0] rxParityBad,
  input  wire logic [1:0] rxStopBad,
  // holding register strobes from the data path
  input  wire logic [1:0] rdDataRd,
  input  wire logic [1:0] txWr,
  input  wire logic [1:0] txLoad,
  // registered outputs: receiver holds, shared-pin data, request
  output logic      [1:0] rxResetOut,
  output logic            clockedSerialRx,
  output logic            irq
);
  // bus writes land one cycle after both halves are held
  // reads answer one edge after the address is taken
  // pins pass two flip-flops before any logic sees them
  // all top-level state, registered as one word
  typedef struct packed {
    // pin synchronisers, two stages each
    logic [1:0] s0, s1, s2;       // carrier, cts0, shared pin
    // write address and data capture
    logic       awPend, wPend;    // item taken, write not yet done
    logic       awRdy, wRdy;      // registered ready outputs
    logic [7:0] awAddr;           // captured write address
    logic [7:0] wData;            // captured write byte
    logic       wByte0;           // lane 0 strobe of the captured word
    // write response
    logic       bvalid;           // response pending
    logic [1:0] bresp;            // response code
    // read channel
    logic       arRdy;            // registered read address ready
    logic       rvalid;           // read data pending
    logic [7:0] rdata;            // read byte, upper lanes zero
    logic [1:0] rresp;            // read response code
    // software registers
    logic [7:0] ctrl0, ctrl1;     // per-channel control
    logic       halt;             // io halt mode
    // interrupt aggregation
    logic [NIRQ-1:0] ist, imask;  // sticky events and their mask
    // registered pin-side outputs
    logic [1:0] rxRst;            // receiver hold per channel
    logic       csRx;             // clocked-serial receive data
    logic       irq;              // level request
  } assf_top_t;
  assf_top_t t_q, t_d;            // present and next state

  // status words shown by the channels
  logic [7:0] async_chan0_status, async_chan1_status;
  // receive request pulses and transmit request levels
  logic [1:0] rxIrqP, txIrqL;
  // bus strobes: write done, read taken, status reads
  logic       doWr, doRd, stat0Rd, stat1Rd;
  // per-channel error clear and status write strobes
  logic [1:0] errWr, statWr;
  // channel 1 clear-to-send after pin steering
  logic       cts1;
  // new events into the sticky status
  logic [NIRQ-1:0] ev;

  // shared pin steering on handshake select
  // select 1: the pin is channel 1 clear-to-send
  // select 0: the pin feeds the clocked-serial receiver instead
  assign cts1 = async_chan1_status[BIT_CD] & t_q.s2[1]; // R15

  // channel 0: carrier-detect pin present, own clear-to-send pin
  // its receiver hold is taken from the status word and registered here
  // its status read strobe drives the carrier clearing
  assf_channel #(.HAS_CARRIER(1'b1)) u_ch0 (
    .mclk        (mclk),
    .nrst        (nrst),
    .haltMode    (t_q.halt),
    .carrierSync (t_q.s0[1]),
    .ctsSync     (t_q.s1[1]),
    .paritySelect(t_q.ctrl0[BIT_PSEL]),
    .errClearWr  (errWr[0]),
    .rxDone      (rxDone[0]),
    .rxParityBad (rxParityBad[0]),
    .rxStopBad   (rxStopBad[0]),
    .rdDataRd    (rdDataRd[0]),
    .statRd      (stat0Rd),
    .txWr        (txWr[0]),
    .txLoad      (txLoad[0]),
    .statWr      (statWr[0]),
    .statWdata   (t_q.wData),
    .status      (async_chan0_status),
    .rxReset     (),
    .rxIrq       (rxIrqP[0]),
    .txIrq       (txIrqL[0])
  );
  // channel 1: no carrier pin, handshake select in place of carrier bit
  // clear-to-send only reaches it through the shared pin steering
  // its receiver is never held
  assf_channel #(.HAS_CARRIER(1'b0)) u_ch1 (
    .mclk        (mclk),
    .nrst        (nrst),
    .haltMode    (t_q.halt),
    .carrierSync (1'b0),
    .ctsSync     (cts1),
    .paritySelect(t_q.ctrl1[BIT_PSEL]),
    .errClearWr  (errWr[1]),
    .rxDone      (rxDone[1]),
    .rxParityBad (rxParityBad[1]),
    .rxStopBad   (rxStopBad[1]),
    .rdDataRd    (rdDataRd[1]),
    .statRd      (stat1Rd),
    .txWr        (txWr[1]),
    .txLoad      (txLoad[1]),
    .statWr      (statWr[1]),
    .statWdata   (t_q.wData),
    .status      (async_chan1_status),
    .rxReset     (),
    .rxIrq       (rxIrqP[1]),
    .txIrq       (txIrqL[1])
  );

  // bus decode and register next state
  // every field holds unless a branch below moves it
  // strobe outputs of this process get values on every path
  always_comb begin
    t_d = t_q;
    // synchronisers: stage 0 read only by stage 1
    // only stage 1 feeds logic, so a metastable stage 0 never spreads
    t_d.s0 = {t_q.s0[0], carrierDetectIn};
    t_d.s1 = {t_q.s1[0], cts0In};
    t_d.s2 = {t_q.s2[0], sharedPin1};
    // write channels, either order
    // each side is captured once and held until the write is done
    // address half
    if (s_axi_awvalid && s_axi_awready) begin
      t_d.awPend = 1'b1;
      t_d.awAddr = s_axi_awaddr;
    end
    // data half: only lane 0 carries register bits
    if (s_axi_wvalid && s_axi_wready) begin
      t_d.wPend  = 1'b1;
      t_d.wData  = s_axi_wdata[7:0];
      t_d.wByte0 = s_axi_wstrb[0];
    end
    // write happens once both halves are held and no response is pending
    doWr    = t_q.awPend & t_q.wPend & ~t_q.bvalid;
    // strobes idle unless the decode below raises them
    errWr   = 2'b00;
    statWr  = 2'b00;
    if (doWr) begin
      // both halves consumed, response raised
      t_d.awPend = 1'b0;
      t_d.wPend  = 1'b0;
      t_d.bvalid = 1'b1;
      // okay unless the decode finds no register
      t_d.bresp  = RESP_OKAY;
      // decode the held address; lane 0 strobe gates every store
      unique case (t_q.awAddr)
        // control: a zero in the clear bit clears the errors
        ADDR_CTRL0:  if (t_q.wByte0) begin
          t_d.ctrl0 = t_q.wData;
          errWr[0]  = ~t_q.wData[BIT_EFC]; // R2
        end
        // channel 1 control, same layout
        ADDR_CTRL1:  if (t_q.wByte0) begin
          t_d.ctrl1 = t_q.wData;
          errWr[1]  = ~t_q.wData[BIT_EFC]; // R2
        end
        // status writes reach only the writable bits
        ADDR_ASYNC_CHAN0_STATUS:  statWr[0] = t_q.wByte0; // R16
        ADDR_ASYNC_CHAN1_STATUS:  statWr[1] = t_q.wByte0; // R16
        // write one to clear the sticky events
        ADDR_IRQST:  if (t_q.wByte0) begin
          t_d.ist = t_q.ist & ~t_q.wData[NIRQ-1:0];
        end
        // mask is plain storage
        ADDR_IRQMSK: if (t_q.wByte0) begin
          t_d.imask = t_q.wData[NIRQ-1:0];
        end
        // bit 0 enters or leaves io halt mode
        ADDR_MODE:   if (t_q.wByte0) begin
          t_d.halt = t_q.wData[0];
        end
        // unmapped write: no effect, error response
        default:     t_d.bresp = RESP_SLVERR;
      endcase
    end
    // response retires at the edge that sees bready
    if (t_q.bvalid && s_axi_bready) begin
      t_d.bvalid = 1'b0;
    end
    // read channel
    // address taken only while no read data is pending
    // status reads are flagged to the channels for carrier clearing
    // read strobes are combinational from the bus inputs
    doRd    = s_axi_arvalid & s_axi_arready;
    stat0Rd = doRd & (s_axi_araddr == ADDR_ASYNC_CHAN0_STATUS); // R7
    stat1Rd = doRd & (s_axi_araddr == ADDR_ASYNC_CHAN1_STATUS);
    if (doRd) begin
      // data pending until rready is seen
      t_d.rvalid = 1'b1;
      // okay unless the decode finds no register
      t_d.rresp  = RESP_OKAY;
      // data captured at the take edge, shown with rvalid
      unique case (s_axi_araddr)
        ADDR_CTRL0:  t_d.rdata = t_q.ctrl0;
        ADDR_CTRL1:  t_d.rdata = t_q.ctrl1;
        ADDR_ASYNC_CHAN0_STATUS:  t_d.rdata = async_chan0_status;
        ADDR_ASYNC_CHAN1_STATUS:  t_d.rdata = async_chan1_status;
        ADDR_IRQST:  t_d.rdata = {4'h0, t_q.ist};
        ADDR_IRQMSK: t_d.rdata = {4'h0, t_q.imask};
        ADDR_MODE:   t_d.rdata = {7'h00, t_q.halt};
        // unmapped read: zero data, error response
        default: begin
          t_d.rdata = 8'h00;
          t_d.rresp = RESP_SLVERR;
        end
      endcase
    end
    // read data retires at the edge that sees rready
    if (t_q.rvalid && s_axi_rready) begin
      t_d.rvalid = 1'b0;
    end
    // sticky events, set wins over clear
    // transmit levels keep re-setting their bit while they stand
    ev     = {txIrqL[1], rxIrqP[1], txIrqL[0], rxIrqP[0]}; // R4 R5 R12
    t_d.ist = t_d.ist | ev;
    // request follows the next status so it moves with it
    t_d.irq = |(t_d.ist & t_d.imask);
    // receiver hold: channel 0 only, channel 1 has no carrier
    t_d.rxRst = {1'b0, async_chan0_status[BIT_CD]}; // R8
    // shared pin to the clocked-serial side while select is 0
    t_d.csRx  = ~async_chan1_status[BIT_CD] & t_q.s2[1]; // R15
    // ready outputs registered from the next pending state
    // so each output comes straight from a flip-flop
    t_d.awRdy = ~t_d.awPend;
    t_d.wRdy  = ~t_d.wPend;
    t_d.arRdy = ~t_d.rvalid;
  end

  // state register, synchronous reset
  // nothing pending after reset, so all three readies start high
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      t_q       <= '0;
      t_q.ctrl0 <= CTRL_RESET;
      t_q.ctrl1 <= CTRL_RESET;
      t_q.awRdy <= 1'b1;
      t_q.wRdy  <= 1'b1;
      t_q.arRdy <= 1'b1;
    end else begin
      // otherwise take the whole next state
      t_q <= t_d;
    end
  end

  // outputs, each straight from a state bit
  // write channel readies and response
  assign s_axi_awready   = t_q.awRdy;
  assign s_axi_wready    = t_q.wRdy;
  assign s_axi_bvalid    = t_q.bvalid;
  assign s_axi_bresp     = t_q.bresp;
  // read channel
  assign s_axi_arready   = t_q.arRdy;
  assign s_axi_rvalid    = t_q.rvalid;
  // rdata: upper three lanes always zero
  assign s_axi_rdata     = {24'h000000, t_q.rdata};
  assign s_axi_rresp     = t_q.rresp;
  // pin-side and interrupt outputs
  assign rxResetOut      = t_q.rxRst;
  assign clockedSerialRx = t_q.csRx;
  assign irq             = t_q.irq;
endmodule
`default_nettype wire
